// >>> tlv_regs.v
// Temperature value, critical limit, hysteresis and identification registers behind a command byte.
// Assumes the serial engine outside decodes each transfer into one-cycle read or write strobes
// with the command byte held on cmd_i, and that conversion results arrive on this clock.
// Also assumes filter_en_i is a steady level taken from filter settings kept elsewhere.
// The limit outputs feed alarm comparators that sit outside this block.
//
// How it works
// - Reading a channel's high byte locks its low byte for a later read.
// - Reading the locked low byte releases the lock so it tracks conversions again.
// - Every high-byte read relatches the low byte, replacing any earlier locked value.
// - Local high byte at 0x10 is read-only two's complement whole degrees.
// - Local low byte at 0x20 is read-only with half, quarter, eighth degree bits.
// - Local low byte bits 4 to 0 always read zero.
// - Remote high bytes at 0x11 and 0x12 are read-only two's complement degrees.
// - Remote low bytes at 0x21 and 0x22 carry fractions; bits 2 to 0 read zero.
// - With a channel's filter off, its low byte bits 4 and 3 read zero.
// - With a channel's filter on, bits 4 and 3 report sixteenth and thirty-second degree.
// - Local critical limit at 0x40 is read/write, resets 0x55, bit 7 stays zero.
// - First remote critical limit at 0x41 is read/write unsigned, resets 0x6E.
// - Second remote channel first limit at 0x42 is read/write unsigned, resets 0x6E.
// - Shared remote limits at 0x49 and 0x4A are read/write unsigned, reset 0x55.
`timescale 1ns/1ps
module tlv_regs #(
  parameter [7:0] MAKER_CODE = 8'h3c,
  parameter [7:0] REVISION_CODE = 8'h07
) (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] cmd_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  input wire [2:0] conv_valid_i,
  input wire [7:0] local_high_i,
  input wire [7:0] local_low_i,
  input wire [7:0] rem1_high_i,
  input wire [7:0] rem1_low_i,
  input wire [7:0] rem2_high_i,
  input wire [7:0] rem2_low_i,
  input wire [1:0] filter_en_i,
  output wire [7:0] rdata_o,
  output wire rack_o,
  output wire wack_o,
  output wire [7:0] local_crit_o,
  output wire [7:0] rem1_first_o,
  output wire [7:0] rem2_first_o,
  output wire [7:0] rem1_shared_o,
  output wire [7:0] rem2_shared_o,
  output wire [7:0] hyst_o
);
`include "tlv_consts.vh"

  reg [7:0] local_crit_r;
  reg [7:0] rem1_first_r;
  reg [7:0] rem2_first_r;
  reg [7:0] rem1_shared_r;
  reg [7:0] rem2_shared_r;
  reg [7:0] hyst_r;
  reg [7:0] rdata_r;
  reg rack_r;
  reg wack_r;
  reg [7:0] rdata_nxt;
  reg [7:0] local_crit_nxt;
  reg [7:0] rem1_first_nxt;
  reg [7:0] rem2_first_nxt;
  reg [7:0] rem1_shared_nxt;
  reg [7:0] rem2_shared_nxt;
  reg [7:0] hyst_nxt;

  wire [7:0] loc_high;
  wire [7:0] loc_low;
  wire [7:0] r1_high;
  wire [7:0] r1_low;
  wire [7:0] r2_high;
  wire [7:0] r2_low;
  wire [7:0] r1_low_vis;
  wire [7:0] r2_low_vis;

  // Reserved bits are cleared as results enter, so locked copies are clean too.
  wire [7:0] loc_low_in = local_low_i & `TLV_MASK_LOCAL_LOW;
  wire [7:0] r1_low_in = rem1_low_i & `TLV_MASK_REM_LOW;
  wire [7:0] r2_low_in = rem2_low_i & `TLV_MASK_REM_LOW;

  wire rd_loc_high = rd_i && (cmd_i == `TLV_CMD_LOCAL_HIGH);
  wire rd_r1_high = rd_i && (cmd_i == `TLV_CMD_REM1_HIGH);
  wire rd_r2_high = rd_i && (cmd_i == `TLV_CMD_REM2_HIGH);
  wire rd_loc_low = rd_i && (cmd_i == `TLV_CMD_LOCAL_LOW);
  wire rd_r1_low = rd_i && (cmd_i == `TLV_CMD_REM1_LOW);
  wire rd_r2_low = rd_i && (cmd_i == `TLV_CMD_REM2_LOW);

  // Each channel keeps its own lock, so reading one channel leaves the others live.
  tlv_chan u_local (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .upd_i(conv_valid_i[0]),
    .high_i(local_high_i),
    .low_i(loc_low_in),
    .rd_high_i(rd_loc_high),
    .rd_low_i(rd_loc_low),
    .high_o(loc_high),
    .low_o(loc_low)
  );

  tlv_chan u_rem1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .upd_i(conv_valid_i[1]),
    .high_i(rem1_high_i),
    .low_i(r1_low_in),
    .rd_high_i(rd_r1_high),
    .rd_low_i(rd_r1_low),
    .high_o(r1_high),
    .low_o(r1_low)
  );

  tlv_chan u_rem2 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .upd_i(conv_valid_i[2]),
    .high_i(rem2_high_i),
    .low_i(r2_low_in),
    .rd_high_i(rd_r2_high),
    .rd_low_i(rd_r2_low),
    .high_o(r2_high),
    .low_o(r2_low)
  );

  // Bits 4 and 3 of a remote low byte read zero while that channel's filter is off.
  function [7:0] rem_low_view;
    input [7:0] low_byte;
    input filt_on;
    begin
      rem_low_view = filt_on ? low_byte : (low_byte & `TLV_MASK_REM_NOFILT);
    end
  endfunction

  // The filter setting is applied when the byte is returned, so it follows the current setting.
  assign r1_low_vis = rem_low_view(r1_low, filter_en_i[0]);
  assign r2_low_vis = rem_low_view(r2_low, filter_en_i[1]);

  always @* begin
    rdata_nxt = `TLV_UNMAPPED_DATA;
    case (cmd_i)
      `TLV_CMD_LOCAL_HIGH: begin
        rdata_nxt = loc_high;
      end
      `TLV_CMD_REM1_HIGH: begin
        rdata_nxt = r1_high;
      end
      `TLV_CMD_REM2_HIGH: begin
        rdata_nxt = r2_high;
      end
      `TLV_CMD_LOCAL_LOW: begin
        rdata_nxt = loc_low;
      end
      `TLV_CMD_REM1_LOW: begin
        rdata_nxt = r1_low_vis;
      end
      `TLV_CMD_REM2_LOW: begin
        rdata_nxt = r2_low_vis;
      end
      `TLV_CMD_LOCAL_CRIT: begin
        rdata_nxt = local_crit_r;
      end
      `TLV_CMD_REM1_FIRST: begin
        rdata_nxt = rem1_first_r;
      end
      `TLV_CMD_REM2_FIRST: begin
        rdata_nxt = rem2_first_r;
      end
      `TLV_CMD_REM1_SHARED: begin
        rdata_nxt = rem1_shared_r;
      end
      `TLV_CMD_REM2_SHARED: begin
        rdata_nxt = rem2_shared_r;
      end
      `TLV_CMD_HYST: begin
        rdata_nxt = hyst_r;
      end
      `TLV_CMD_MAKER: begin
        rdata_nxt = MAKER_CODE;
      end
      `TLV_CMD_REVISION: begin
        rdata_nxt = REVISION_CODE;
      end
      default: begin
        rdata_nxt = `TLV_UNMAPPED_DATA;
      end
    endcase
  end

  // Read data is captured on the strobe and held until the next read.
  // A write in the same cycle does not show yet: the read returns the value before it.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= `TLV_RST_DATA;
      rack_r <= 1'b0;
    end else begin
      rack_r <= rd_i;
      if (rd_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Next values of the writable registers: each one holds unless a write names it.
  // A write to a value or identification code is acknowledged and then dropped, so a
  // host that writes a read-only code by mistake cannot disturb any stored byte.
  always @* begin
    local_crit_nxt = local_crit_r;
    rem1_first_nxt = rem1_first_r;
    rem2_first_nxt = rem2_first_r;
    rem1_shared_nxt = rem1_shared_r;
    rem2_shared_nxt = rem2_shared_r;
    hyst_nxt = hyst_r;

    if (wr_i) begin
      case (cmd_i)
        `TLV_CMD_LOCAL_CRIT: begin
          local_crit_nxt = wdata_i & `TLV_MASK_LOCAL_CRIT;
        end
        `TLV_CMD_REM1_FIRST: begin
          rem1_first_nxt = wdata_i;
        end
        `TLV_CMD_REM2_FIRST: begin
          rem2_first_nxt = wdata_i;
        end
        `TLV_CMD_REM1_SHARED: begin
          rem1_shared_nxt = wdata_i;
        end
        `TLV_CMD_REM2_SHARED: begin
          rem2_shared_nxt = wdata_i;
        end
        `TLV_CMD_HYST: begin
          hyst_nxt = wdata_i & `TLV_MASK_HYST;
        end
        // Value codes: these bytes come only from conversion results.
        `TLV_CMD_LOCAL_HIGH: begin
          hyst_nxt = hyst_r;
        end
        `TLV_CMD_REM1_HIGH: begin
          hyst_nxt = hyst_r;
        end
        `TLV_CMD_REM2_HIGH: begin
          hyst_nxt = hyst_r;
        end
        `TLV_CMD_LOCAL_LOW: begin
          hyst_nxt = hyst_r;
        end
        `TLV_CMD_REM1_LOW: begin
          hyst_nxt = hyst_r;
        end
        `TLV_CMD_REM2_LOW: begin
          hyst_nxt = hyst_r;
        end
        // Identification codes: these bytes come only from the parameters.
        `TLV_CMD_MAKER: begin
          hyst_nxt = hyst_r;
        end
        `TLV_CMD_REVISION: begin
          hyst_nxt = hyst_r;
        end
        default: begin
          hyst_nxt = hyst_r;
        end
      endcase
    end
  end

  // Only the limit and hysteresis registers hold data.
  // The acknowledge answers every write, whatever its code.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      local_crit_r <= `TLV_RST_LOCAL_CRIT;
      rem1_first_r <= `TLV_RST_FIRST;
      rem2_first_r <= `TLV_RST_FIRST;
      rem1_shared_r <= `TLV_RST_SHARED;
      rem2_shared_r <= `TLV_RST_SHARED;
      hyst_r <= `TLV_RST_HYST;
      wack_r <= 1'b0;
    end else begin
      wack_r <= wr_i;
      local_crit_r <= local_crit_nxt;
      rem1_first_r <= rem1_first_nxt;
      rem2_first_r <= rem2_first_nxt;
      rem1_shared_r <= rem1_shared_nxt;
      rem2_shared_r <= rem2_shared_nxt;
      hyst_r <= hyst_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign rack_o = rack_r;
  assign wack_o = wack_r;
  assign local_crit_o = local_crit_r;
  assign rem1_first_o = rem1_first_r;
  assign rem2_first_o = rem2_first_r;
  assign rem1_shared_o = rem1_shared_r;
  assign rem2_shared_o = rem2_shared_r;
  assign hyst_o = hyst_r;

endmodule // tlv_regs

// >>> tlv_consts.vh
// Command codes, field masks and power-on values for the temperature readout registers.
// Assumes an 8-bit command byte selects one register per access.
`ifndef TLV_CONSTS_VH
`define TLV_CONSTS_VH

`define TLV_CMD_LOCAL_HIGH 8'h10
`define TLV_CMD_REM1_HIGH 8'h11
`define TLV_CMD_REM2_HIGH 8'h12
`define TLV_CMD_LOCAL_LOW 8'h20
`define TLV_CMD_REM1_LOW 8'h21
`define TLV_CMD_REM2_LOW 8'h22
`define TLV_CMD_LOCAL_CRIT 8'h40
`define TLV_CMD_REM1_FIRST 8'h41
`define TLV_CMD_REM2_FIRST 8'h42
`define TLV_CMD_REM1_SHARED 8'h49
`define TLV_CMD_REM2_SHARED 8'h4a
`define TLV_CMD_HYST 8'h5a
`define TLV_CMD_MAKER 8'hfe
`define TLV_CMD_REVISION 8'hff

`define TLV_RST_LOCAL_CRIT 8'h55
`define TLV_RST_FIRST 8'h6e
`define TLV_RST_SHARED 8'h55
`define TLV_RST_HYST 8'h0a
`define TLV_RST_TEMP 8'h00
`define TLV_RST_DATA 8'h00

`define TLV_MASK_LOCAL_CRIT 8'h7f
`define TLV_MASK_HYST 8'h1f
`define TLV_MASK_LOCAL_LOW 8'he0
`define TLV_MASK_REM_LOW 8'hf8
`define TLV_MASK_REM_NOFILT 8'he0
`define TLV_UNMAPPED_DATA 8'h00

`endif

// >>> tlv_chan.v
// One temperature channel: live high and low bytes plus the low-byte lock.
// Assumes read strobes are single-cycle pulses on the same clock as conversion updates.
`timescale 1ns/1ps
module tlv_chan (
  input wire clk_i,
  input wire reset_i,
  input wire upd_i,
  input wire [7:0] high_i,
  input wire [7:0] low_i,
  input wire rd_high_i,
  input wire rd_low_i,
  output wire [7:0] high_o,
  output wire [7:0] low_o
);
`include "tlv_consts.vh"

  reg [7:0] high_r;
  reg [7:0] low_r;
  reg [7:0] held_low_r;
  reg lock_r;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_r <= `TLV_RST_TEMP;
      low_r <= `TLV_RST_TEMP;
    end else if (upd_i) begin
      high_r <= high_i;
      low_r <= low_i;
    end
  end

  // The held copy is the low byte that belonged to the high byte just returned.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      held_low_r <= `TLV_RST_TEMP;
      lock_r <= 1'b0;
    end else if (rd_high_i) begin
      held_low_r <= low_r;
      lock_r <= 1'b1;
    end else if (rd_low_i) begin
      lock_r <= 1'b0;
    end
  end

  assign high_o = high_r;
  assign low_o = lock_r ? held_low_r : low_r;

endmodule // tlv_chan

// >>> tlv_regs_asserts.sv
// Timing and field checks on the readout register block.
// Assumes it is bound to every tlv_regs instance.
`timescale 1ns/1ps
module tlv_regs_asserts (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] cmd_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  input wire [1:0] filter_en_i,
  input wire [7:0] rdata_o,
  input wire rack_o,
  input wire wack_o,
  input wire [7:0] local_crit_o,
  input wire [7:0] rem1_first_o,
  input wire [7:0] rem2_shared_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_read_answer: assert property (rd_i |=> rack_o) else $error("read missed");
  a_write_answer: assert property (wr_i |=> wack_o) else $error("write missed");
  a_crit_write: assert property (wr_i && cmd_i == 8'h40 |=> local_crit_o == ($past(wdata_i) & 8'h7f))
    else $error("local limit bad");
  a_crit_msb: assert property (local_crit_o[7] == 1'b0) else $error("limit msb set");
  a_first_write: assert property (wr_i && cmd_i == 8'h41 |=> rem1_first_o == $past(wdata_i))
    else $error("first limit bad");
  a_first_hold: assert property (!(wr_i && cmd_i == 8'h41) |=> $stable(rem1_first_o))
    else $error("first limit moved");
  a_shared_write: assert property (wr_i && cmd_i == 8'h4a |=> rem2_shared_o == $past(wdata_i))
    else $error("shared limit bad");
  a_local_low: assert property (rd_i && cmd_i == 8'h20 |=> rdata_o[4:0] == 5'h00)
    else $error("local low bits");
  a_filter_off: assert property (rd_i && cmd_i == 8'h21 && !filter_en_i[0] |=> rdata_o[4:0] == 5'h00)
    else $error("filter off bits");
  a_rem_low: assert property (rd_i && cmd_i == 8'h22 |=> rdata_o[2:0] == 3'h0)
    else $error("remote low bits");
  cover property (rd_i && cmd_i == 8'h21 && filter_en_i[0]);
  cover property (wr_i && cmd_i == 8'h40);
  cover property (rd_i && cmd_i == 8'h10 ##[1:4] rd_i && cmd_i == 8'h20);
endmodule // tlv_regs_asserts
bind tlv_regs tlv_regs_asserts tlv_regs_asserts_i (.clk_i(clk_i), .reset_i(reset_i), .cmd_i(cmd_i),
  .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .filter_en_i(filter_en_i), .rdata_o(rdata_o),
  .rack_o(rack_o), .wack_o(wack_o), .local_crit_o(local_crit_o), .rem1_first_o(rem1_first_o),
  .rem2_shared_o(rem2_shared_o));

// >>> tlv_host.sv
// Register host model: one strobe per access, answer taken one cycle later.
// Assumes the device answers a read with rack_i and registered rdata_i, and a write with wack_i.
`timescale 1ns/1ps
module tlv_host (
  input wire clk_i,
  input wire rack_i,
  input wire wack_i,
  input wire [7:0] rdata_i,
  output reg [7:0] cmd_o = 8'h00,
  output reg rd_o = 1'b0,
  output reg wr_o = 1'b0,
  output reg [7:0] wdata_o = 8'h00
);
  // Released command and data lines show the inverse so stale values never look valid.
  task xfer(input w, input [7:0] c, input [7:0] d, output [7:0] q, output ok);
    begin
      @(posedge clk_i);
      cmd_o <= c;
      wdata_o <= d;
      rd_o <= !w;
      wr_o <= w;
      @(posedge clk_i);
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      cmd_o <= ~c;
      wdata_o <= ~d;
      @(posedge clk_i);
      q = rdata_i;
      ok = w ? wack_i : rack_i;
    end
  endtask
endmodule // tlv_host

// >>> tlv_regs_tb_top.sv
// Self-checking bench for the readout registers with random conversion data.
// Assumes tlv_host makes the register accesses and the checker is bound.
`timescale 1ns/1ps
module tlv_regs_tb_top;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [2:0] conv_valid_i = 3'h0;
  reg [7:0] hi_r = 8'h00;
  reg [7:0] lo_r = 8'h00;
  reg [1:0] filter_en_i = 2'h0;
  wire [7:0] cmd, wdata, rdata, lc, r1f, r2f, r1s, r2s, hy;
  wire rd, wr, rack, wack;
  integer error_cnt = 0;
  integer checked = 0;
  integer i;
  reg [31:0] seed = 32'h0001_5c63;
  reg [7:0] q, h, l, a, c;
  reg ok, f;
  reg [7:0] tab [0:5] = '{8'h40, 8'h41, 8'h42, 8'h49, 8'h4a, 8'h5a};
  reg [7:0] rtab [0:5] = '{8'h55, 8'h6e, 8'h6e, 8'h55, 8'h55, 8'h0a};
  tlv_host tlv_host_i (.clk_i(clk_i), .rack_i(rack), .wack_i(wack), .rdata_i(rdata), .cmd_o(cmd), .rd_o(rd),
    .wr_o(wr), .wdata_o(wdata));
  // Identification values below are arbitrary.
  tlv_regs #(.MAKER_CODE(8'h5d), .REVISION_CODE(8'h2b)) tlv_regs_i (.clk_i(clk_i), .reset_i(reset_i),
    .cmd_i(cmd), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .conv_valid_i(conv_valid_i), .local_high_i(hi_r),
    .local_low_i(lo_r), .rem1_high_i(hi_r), .rem1_low_i(lo_r), .rem2_high_i(hi_r), .rem2_low_i(lo_r),
    .filter_en_i(filter_en_i), .rdata_o(rdata), .rack_o(rack), .wack_o(wack), .local_crit_o(lc),
    .rem1_first_o(r1f), .rem2_first_o(r2f), .rem1_shared_o(r1s), .rem2_shared_o(r2s), .hyst_o(hy));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [7:0] lowx(input [7:0] ch, input [7:0] v, input fl);
    lowx = (ch == 8'h00 || !fl) ? v & 8'he0 : v & 8'hf8;
  endfunction
  function [7:0] wmask(input [7:0] cm);
    wmask = cm == 8'h40 ? 8'h7f : cm == 8'h5a ? 8'h1f : 8'hff;
  endfunction
  function [7:0] limv(input [7:0] cm);
    case (cm)
      8'h40: limv = lc;
      8'h41: limv = r1f;
      8'h42: limv = r2f;
      8'h49: limv = r1s;
      8'h4a: limv = r2s;
      default: limv = hy;
    endcase
  endfunction
  task chk(input [7:0] n, input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value reg %h exp %h got %h", n, exp, got);
      end
    end
  endtask
  task rdc(input [7:0] n, input [7:0] exp);
    begin
      tlv_host_i.xfer(1'b0, n, 8'h00, q, ok);
      chk(n, {7'h0, ok}, 8'h01);
      chk(n, q, exp);
    end
  endtask
  task wrc(input [7:0] n, input [7:0] d);
    begin
      tlv_host_i.xfer(1'b1, n, d, q, ok);
      chk(n, {7'h0, ok}, 8'h01);
    end
  endtask
  task chk_defaults;
    for (i = 0; i < 6; i = i + 1) begin
      rdc(tab[i], rtab[i]);
      chk(tab[i], limv(tab[i]), rtab[i]);
    end
  endtask
  task conv(input [7:0] ch);
    begin
      seed = xs(seed);
      h = seed[7:0];
      l = seed[15:8];
      @(posedge clk_i);
      hi_r <= h;
      lo_r <= l;
      conv_valid_i <= 3'h1 << ch;
      @(posedge clk_i);
      conv_valid_i <= 3'h0;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #(4000 * 50);
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    chk_defaults;
    wrc(8'h40, 8'hff);
    rdc(8'h40, 8'h7f);
    for (i = 0; i < 12; i = i + 1) begin
      seed = xs(seed);
      c = tab[i % 6];
      wrc(c, seed[7:0]);
      rdc(c, seed[7:0] & wmask(c));
      chk(c, limv(c), seed[7:0] & wmask(c));
    end
    wrc(8'hfe, 8'h00);
    rdc(8'hfe, 8'h5d);
    wrc(8'hff, 8'h00);
    rdc(8'hff, 8'h2b);
    rdc(8'h33, 8'h00);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    chk_defaults;
    for (i = 0; i < 6; i = i + 1) begin
      c = i % 3;
      f = i / 3;
      filter_en_i <= (c == 8'h02) ? {f, !f} : {!f, f};
      conv(c);
      rdc(8'h10 + c, h);
      conv(c);
      rdc(8'h10 + c, h);
      a = l;
      conv(c);
      rdc(8'h20 + c, lowx(c, a, f));
      rdc(8'h20 + c, lowx(c, l, f));
      wrc(8'h10 + c, ~h);
      rdc(8'h10 + c, h);
    end
    conclude;
  end
endmodule // tlv_regs_tb_top
